// ==== rtl/eccc_map.svh ====
// How it works
// - unit query: opcode 19h then address
// - low three address bits ignored, unit selected
// - memory latency code sets dummy cycles
// - one status byte out, then chip select
// - extra clocks give undefined data, no advance
// - status bit 3 is triple error, others zero
// - opcode 1Bh clears flags, trap, counter
// - clear runs without write enable latch
// - checksum covers main array only
// - opcodes 5B, 75, 7A, single rate only; the code also takes them in dual and quad lane modes
// - opcode, start, end; chip select rise launches
// - late chip select rise discards the command
// - runs regardless of latch; clears latch after
// - end below start plus three aborts, flag set
// - write in progress high while calculating
// - 32-bit result readable via register read
// - result zeroed at start and reset
// - suspended flag set; reads allowed meanwhile
// - both boundary bytes are included
// - Castagnoli polynomial 0x1EDC6F41
// - lowest address byte goes to top bits
// - query has three address bytes, single rate; the code also serves it in dual and quad lane modes
// - resume acts only while suspended
`ifndef ECCC_MAP_SVH
`define ECCC_MAP_SVH
// ==========================================================
// command opcodes
`define ECCC_OPC_UNIT_QUERY 8'h19
`define ECCC_OPC_LOG_CLEAR 8'h1b
`define ECCC_OPC_CK_START 8'h5b
`define ECCC_OPC_CK_SUSPEND 8'h75
`define ECCC_OPC_CK_RESUME 8'h7a
// ==========================================================
// field positions and frame lengths
`define ECCC_OP_BITS 7'h08
`define ECCC_ADDR_BITS 7'h18
`define ECCC_UNIT_LOW_BITS 3
`define ECCC_UNIT_ERR_BIT 3
`define ECCC_LANE_DUAL 2'h1
`define ECCC_LANE_QUAD 2'h2
// ==========================================================
// checksum constants and reset values
`define ECCC_CK_POLY 32'h1edc6f41
`define ECCC_CK_RESULT_RST 32'h00000000
`define ECCC_CK_MIN_SPAN 25'h0000003
`define ECCC_STATUS_RST 8'h00
`endif

// ==== rtl/eccc_pkg.sv ====
// ==========================================================
// shared types
package eccc_pkg;
	// checksum engine states
	typedef enum logic [1:0] {ENG_IDLE, ENG_FETCH, ENG_FOLD, ENG_SUSP} eccc_eng_t;
	// command held by the link side until the next frame
	typedef struct packed {
		logic [7:0] op;
		logic [23:0] sa;
		logic [23:0] ea;
		logic [23:0] qa;
		logic done;
	} eccc_cmd_t;
endpackage : eccc_pkg

// ==== rtl/eccc_sync3.sv ====
// ==========================================================
// three stage level synchroniser, change taken on agreement
module eccc_sync3
	import eccc_pkg::*;
(
	input wire logic clk, // destination clock
	input wire logic rst, // synchronous reset, high
	input wire logic din, // level from another domain
	output logic dout // filtered level
);
	logic s1_r; // first stage, read by s2 only
	logic s2_r; // second stage
	logic s3_r; // third stage
	// shift chain
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
		end
		else
		begin
			s1_r <= din;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end
	// output follows once stages two and three agree
	always_ff @(posedge clk)
	begin
		if (rst)
			dout <= 1'b0;
		else if (s2_r == s3_r)
			dout <= s3_r;
	end
endmodule : eccc_sync3

// ==== rtl/eccc_engine.sv ====
`include "eccc_map.svh"
// ==========================================================
// unit error query, error log clear and checksum engine
module eccc_engine
	import eccc_pkg::*;
(
	input wire logic core_clk, // core clock, 50 MHz
	input wire logic reset, // synchronous reset, high
	input wire logic link_sclk, // serial clock from host
	input wire logic link_cs_n, // chip select, low active
	input wire logic [3:0] io_in, // serial lanes in
	output logic [3:0] io_out, // serial lanes out
	output logic [3:0] io_oe, // lane drive enables
	input wire logic [1:0] lane_mode, // single, dual, quad
	input wire logic [3:0] memory_latency_code, // dummy cycles
	output logic [20:0] unit_query_addr, // queried unit index
	input wire logic unit_triple_error, // error in that unit
	output logic arr_req, // array word request
	output logic [23:0] arr_addr, // array byte address
	input wire logic arr_ack, // word ready pulse
	input wire logic [31:0] arr_rdata, // byte n at [8n+7:8n]
	input wire logic write_enable_latch, // latch level
	output logic wel_clear, // pulse: clear the latch
	output logic error_log_clear_cmd, // pulse: clear ecc log
	output logic write_in_progress, // checksum busy
	output logic checksum_abort_flag, // span too short
	output logic checksum_suspended_flag, // paused
	output logic [31:0] checksum_result // result register
);
	// ======================================================
	// link side: frame counter and command capture
	eccc_cmd_t cmd_r; // held command, stable while cs high
	logic [6:0] cyc_r; // sclk edges since cs fall
	logic [6:0] cyc_nxt; // count including this edge
	logic [23:0] sh_r; // input shift register
	logic [23:0] sh_nxt; // shift value with new lanes
	logic [6:0] op_end; // edges for the opcode
	logic [6:0] a_cyc; // edges for one address
	logic [6:0] out_start; // first status output edge
	logic [7:0] osh_r; // status bits still to send
	logic qreq_r; // query request level toward core
	logic qack_l; // core ack seen in link domain
	logic qack_r; // query ack level from core
	logic [7:0] status_r; // unit error status byte
	logic [7:0] stat_sel; // byte to present
	logic in_out; // this edge presents status bits
	logic [3:0] lane_bits; // top bits being presented
	logic [7:0] osh_src; // byte being shifted out

	assign cyc_nxt = cyc_r + 7'h01;
	// edge counts per field for the lane width
	always_comb
	begin
		op_end = `ECCC_OP_BITS;
		a_cyc = `ECCC_ADDR_BITS;
		sh_nxt = {sh_r[22:0], io_in[0]};
		if (lane_mode == `ECCC_LANE_DUAL)
		begin
			op_end = `ECCC_OP_BITS >> 1;
			a_cyc = `ECCC_ADDR_BITS >> 1;
			sh_nxt = {sh_r[21:0], io_in[1:0]};
		end
		else if (lane_mode == `ECCC_LANE_QUAD)
		begin
			op_end = `ECCC_OP_BITS >> 2;
			a_cyc = `ECCC_ADDR_BITS >> 2;
			sh_nxt = {sh_r[19:0], io_in};
		end
	end
	// dummy cycles follow the memory latency code
	assign out_start = op_end + a_cyc + {3'h0, memory_latency_code};
	assign in_out = cmd_r.op == `ECCC_OPC_UNIT_QUERY &&
		cyc_nxt >= out_start && cyc_nxt < out_start + op_end;
	// byte reads zero until this frame's lookup is acknowledged
	assign stat_sel = qack_l ? status_r : `ECCC_STATUS_RST;
	assign osh_src = (cyc_nxt == out_start) ? stat_sel : osh_r;

	// frame counter, cleared while deselected
	always_ff @(posedge link_sclk or posedge link_cs_n)
	begin
		if (link_cs_n)
			cyc_r <= 7'h00;
		else if (cyc_r != 7'h7f)
			cyc_r <= cyc_nxt;
	end
	// opcode and address capture; survives cs rise
	always_ff @(posedge link_sclk)
	begin
		sh_r <= sh_nxt;
		if (cyc_nxt == op_end)
		begin
			cmd_r.op <= sh_nxt[7:0];
			// only the listed codes are recognised
			cmd_r.done <= sh_nxt[7:0] == `ECCC_OPC_LOG_CLEAR ||
				sh_nxt[7:0] == `ECCC_OPC_CK_SUSPEND ||
				sh_nxt[7:0] == `ECCC_OPC_CK_RESUME;
		end
		else if (cyc_nxt == op_end + a_cyc)
		begin
			cmd_r.done <= 1'b0;
			// three address bytes, then the query goes out
			if (cmd_r.op == `ECCC_OPC_UNIT_QUERY)
				cmd_r.qa <= sh_nxt;
			if (cmd_r.op == `ECCC_OPC_CK_START)
				cmd_r.sa <= sh_nxt;
		end
		else if (cyc_nxt == op_end + a_cyc + a_cyc &&
			cmd_r.op == `ECCC_OPC_CK_START)
		begin
			// armed only if cs rises before another edge
			cmd_r.ea <= sh_nxt;
			cmd_r.done <= 1'b1;
		end
		else
			cmd_r.done <= 1'b0;
	end
	// query request level, dropped when the frame ends
	always_ff @(posedge link_sclk or posedge link_cs_n)
	begin
		if (link_cs_n)
			qreq_r <= 1'b0;
		else if (cyc_nxt == op_end + a_cyc &&
			cmd_r.op == `ECCC_OPC_UNIT_QUERY)
			qreq_r <= 1'b1;
	end
	// status byte shift out, one unit per query
	always_ff @(posedge link_sclk or posedge link_cs_n)
	begin
		if (link_cs_n)
		begin
			osh_r <= `ECCC_STATUS_RST;
			io_out <= 4'h0;
			io_oe <= 4'h0;
		end
		else if (in_out)
		begin
			io_out <= lane_bits;
			if (lane_mode == `ECCC_LANE_QUAD)
			begin
				osh_r <= {osh_src[3:0], 4'h0};
				io_oe <= 4'hf;
			end
			else if (lane_mode == `ECCC_LANE_DUAL)
			begin
				osh_r <= {osh_src[5:0], 2'h0};
				io_oe <= 4'h3;
			end
			else
			begin
				osh_r <= {osh_src[6:0], 1'b0};
				io_oe <= 4'h2;
			end
		end
		else
		begin
			// past the byte the lanes just float
			io_out <= 4'h0;
			io_oe <= 4'h0;
		end
	end
	// lane mapping of the bits being presented
	always_comb
	begin
		if (lane_mode == `ECCC_LANE_QUAD)
			lane_bits = osh_src[7:4];
		else if (lane_mode == `ECCC_LANE_DUAL)
			lane_bits = {2'h0, osh_src[7:6]};
		else
			lane_bits = {2'h0, osh_src[7], 1'b0};
	end
	// query ack into the link domain
	eccc_sync3 u_ack_sync (
		.clk(link_sclk),
		.rst(1'b0),
		.din(qack_r),
		.dout(qack_l)
	);

	// ======================================================
	// core side: crossings and unit status lookup
	logic cs_q; // synchronised select, high while selected
	logic cs_seen_r; // previous value
	logic cs_rise; // frame just ended
	logic qreq_q; // synchronised query request
	logic qseen_r; // previous request level
	logic q_ev; // new query
	logic qstage_r; // lookup in progress
	logic cmd_ok; // a complete command ended the frame

	eccc_sync3 u_cs_sync (
		.clk(core_clk),
		.rst(reset),
		.din(~link_cs_n),
		.dout(cs_q)
	);
	eccc_sync3 u_req_sync (
		.clk(core_clk),
		.rst(reset),
		.din(qreq_r),
		.dout(qreq_q)
	);
	// idle select level equals the reset level: no false edge
	assign cs_rise = ~cs_q & cs_seen_r;
	assign q_ev = qreq_q & ~qseen_r;
	assign cmd_ok = cs_rise & cmd_r.done;

	// edge memories
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			cs_seen_r <= 1'b0;
			qseen_r <= 1'b0;
		end
		else
		begin
			cs_seen_r <= cs_q;
			qseen_r <= qreq_q;
		end
	end
	// unit lookup: address out, then capture the flag
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			unit_query_addr <= 21'h000000;
			qstage_r <= 1'b0;
			qack_r <= 1'b0;
			status_r <= `ECCC_STATUS_RST;
		end
		else if (q_ev)
		begin
			unit_query_addr <= cmd_r.qa[23:`ECCC_UNIT_LOW_BITS];
			qstage_r <= 1'b1;
		end
		else if (qstage_r)
		begin
			status_r <= `ECCC_STATUS_RST;
			status_r[`ECCC_UNIT_ERR_BIT] <= unit_triple_error;
			qack_r <= 1'b1;
			qstage_r <= 1'b0;
		end
		else if (!qreq_q)
			qack_r <= 1'b0; // ack drops once the frame is over
	end
	// error log clear pulse, no latch check
	always_ff @(posedge core_clk)
	begin
		if (reset)
			error_log_clear_cmd <= 1'b0;
		else
			error_log_clear_cmd <= cmd_ok &&
				cmd_r.op == `ECCC_OPC_LOG_CLEAR;
	end

	// ======================================================
	// checksum engine
	eccc_eng_t state_r; // engine state
	logic [23:0] cur_r; // next byte address
	logic [23:0] end_r; // last byte address
	logic [31:0] word_r; // fetched word, low address on top
	logic susp_pend_r; // suspend waiting for word boundary
	logic [23:0] rem; // bytes left minus one
	logic [2:0] nbytes; // valid bytes in this word
	logic last_w; // this word reaches the end
	logic start_ok; // legal start request
	logic start_bad; // too short a span

	assign rem = end_r - cur_r;
	assign nbytes = (rem >= 24'h000003) ? 3'h4 : rem[2:0] + 3'h1;
	assign last_w = rem <= 24'h000003;
	assign start_bad = {1'b0, cmd_r.ea} <
		{1'b0, cmd_r.sa} + `ECCC_CK_MIN_SPAN;
	assign start_ok = cmd_ok && cmd_r.op == `ECCC_OPC_CK_START &&
		state_r == ENG_IDLE;

	// msb-first fold of the valid bytes, zero seed
	function automatic logic [31:0] ck_fold(input logic [31:0] c,
		input logic [31:0] w, input logic [2:0] nb);
		logic [31:0] r;
		logic fb;
		r = c;
		fb = 1'b0;
		for (int i = 0; i < 32; i++)
		begin
			if (i < {nb, 3'h0})
			begin
				fb = r[31] ^ w[31 - i];
				r = {r[30:0], 1'b0};
				if (fb)
					r = r ^ `ECCC_CK_POLY;
			end
		end
		return r;
	endfunction : ck_fold

	// engine sequencing
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			state_r <= ENG_IDLE;
			cur_r <= 24'h000000;
			end_r <= 24'h000000;
			susp_pend_r <= 1'b0;
		end
		else
		begin
			unique case (state_r)
				ENG_IDLE:
				begin
					if (start_ok && !start_bad)
					begin
						cur_r <= cmd_r.sa;
						end_r <= cmd_r.ea;
						susp_pend_r <= 1'b0;
						state_r <= ENG_FETCH;
					end
				end
				ENG_FETCH:
				begin
					if (arr_ack)
						state_r <= ENG_FOLD;
				end
				ENG_FOLD:
				begin
					cur_r <= cur_r + 24'h000004;
					susp_pend_r <= 1'b0;
					if (last_w)
						state_r <= ENG_IDLE;
					else if (susp_pend_r)
						state_r <= ENG_SUSP;
					else
						state_r <= ENG_FETCH;
				end
				ENG_SUSP:
				begin
					if (cmd_ok && cmd_r.op == `ECCC_OPC_CK_RESUME)
						state_r <= ENG_FETCH;
				end
			endcase
			if (cmd_ok && cmd_r.op == `ECCC_OPC_CK_SUSPEND &&
				(state_r == ENG_FETCH || state_r == ENG_FOLD))
				susp_pend_r <= 1'b1;
		end
	end
	// array fetch port, main array addresses only
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			arr_req <= 1'b0;
			arr_addr <= 24'h000000;
			word_r <= 32'h00000000;
		end
		else
		begin
			arr_req <= state_r == ENG_FETCH && !arr_ack;
			arr_addr <= cur_r;
			if (arr_ack)
				word_r <= {arr_rdata[7:0], arr_rdata[15:8],
					arr_rdata[23:16], arr_rdata[31:24]};
		end
	end
	// result register
	always_ff @(posedge core_clk)
	begin
		if (reset)
			checksum_result <= `ECCC_CK_RESULT_RST;
		else if (start_ok)
			checksum_result <= `ECCC_CK_RESULT_RST;
		else if (state_r == ENG_FOLD)
			checksum_result <= ck_fold(checksum_result,
				word_r, nbytes);
	end
	// status flags and latch clear
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			write_in_progress <= 1'b0;
			checksum_abort_flag <= 1'b0;
			checksum_suspended_flag <= 1'b0;
			wel_clear <= 1'b0;
		end
		else
		begin
			wel_clear <= state_r == ENG_FOLD && last_w &&
				write_enable_latch;
			if (start_ok)
			begin
				checksum_abort_flag <= start_bad;
				write_in_progress <= !start_bad;
			end
			else if (state_r == ENG_FOLD && (last_w || susp_pend_r))
			begin
				write_in_progress <= 1'b0;
				checksum_suspended_flag <= !last_w;
			end
			else if (state_r == ENG_SUSP && cmd_ok &&
				cmd_r.op == `ECCC_OPC_CK_RESUME)
			begin
				write_in_progress <= 1'b1;
				checksum_suspended_flag <= 1'b0;
			end
		end
	end

	// ======================================================
	// checks
	property p_wip_busy;
		@(posedge core_clk) disable iff (reset)
		(state_r == ENG_FETCH) |-> write_in_progress;
	endproperty
	a_wip_busy: assert property (p_wip_busy)
		else $error("busy without write in progress");
	property p_abort;
		@(posedge core_clk) disable iff (reset)
		(start_ok && start_bad) |=> checksum_abort_flag &&
			!write_in_progress && state_r == ENG_IDLE;
	endproperty
	a_abort: assert property (p_abort)
		else $error("short span not aborted");
	property p_start_zero;
		@(posedge core_clk) disable iff (reset)
		(start_ok && !start_bad) |=> checksum_result == 32'h0 &&
			write_in_progress ##1 arr_req;
	endproperty
	a_start_zero: assert property (p_start_zero)
		else $error("start did not zero result");
	property p_susp;
		@(posedge core_clk) disable iff (reset)
		(state_r == ENG_SUSP) |-> checksum_suspended_flag &&
			!write_in_progress && !arr_req;
	endproperty
	a_susp: assert property (p_susp)
		else $error("suspend state flags wrong");
	property p_resume_ign;
		@(posedge core_clk) disable iff (reset)
		(state_r == ENG_IDLE && !start_ok) |=>
			!checksum_suspended_flag || $stable(checksum_suspended_flag);
	endproperty
	a_resume_ign: assert property (p_resume_ign)
		else $error("suspended flag changed while idle");
	property p_wel;
		@(posedge core_clk) disable iff (reset)
		(state_r == ENG_FOLD && last_w && write_enable_latch)
			|=> wel_clear ##1 !write_in_progress;
	endproperty
	a_wel: assert property (p_wel)
		else $error("latch not cleared at completion");
	property p_clr;
		@(posedge core_clk) disable iff (reset)
		(cmd_ok && cmd_r.op == `ECCC_OPC_LOG_CLEAR)
			|=> error_log_clear_cmd ##1 !error_log_clear_cmd;
	endproperty
	a_clr: assert property (p_clr)
		else $error("clear pulse missing");
	property p_unit;
		@(posedge core_clk) disable iff (reset)
		q_ev |=> unit_query_addr == $past(cmd_r.qa[23:3])
			##1 status_r[7:4] == 4'h0 && status_r[2:0] == 3'h0;
	endproperty
	a_unit: assert property (p_unit)
		else $error("unit status lookup wrong");
endmodule : eccc_engine

// ==== test/eccc_host_model.sv ====
// ==========
// host serial controller model; clock stands still outside frames
module eccc_host_model
	import eccc_pkg::*;
(
	output logic link_sclk, // serial clock, idle low
	output logic link_cs_n, // chip select, low active
	output logic [3:0] io_in, // lanes toward the device
	input wire logic [3:0] io_out, // lanes from the device
	input wire logic [1:0] lane_mode // lane width code
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [3:0] smp; // lanes seen just before a rise

	// idle levels; an initial select rise clears the frame logic
	initial
	begin
		link_sclk = 1'b0;
		link_cs_n = 1'b0;
		io_in = 4'h5;
		#1;
		link_cs_n = 1'b1;
	end

	// one serial edge, 32 ns period; answer sampled before the rise
	task automatic tick(input logic [3:0] d);
		io_in = d;
		#16;
		smp = io_out;
		link_sclk = 1'b1;
		#16;
		link_sclk = 1'b0;
	endtask : tick

	// shift a field msb first over the active lanes
	task automatic put(input logic [23:0] v, input int nb);
		logic [23:0] s;
		int i;
		s = v;
		for (i = 0; i < nb; i += 1 << lane_mode)
		begin
			tick(s[23:20] >> (4 - (1 << lane_mode)));
			s = s << (1 << lane_mode);
		end
	endtask : put

	// whole frame: opcode, addresses, dummies, answer byte, extra edges
	task automatic frame(input logic [7:0] op, input logic [23:0] a1,
		input logic [23:0] a2, input int na, input int dly, input int nx,
		output logic [7:0] rd);
		int i;
		rd = 8'h00;
		#3;
		link_cs_n = 1'b0;
		#8;
		put({op, 16'h0000}, 8);
		if (na > 0)
			put(a1, 24);
		if (na > 1)
			put(a2, 24);
		if (dly > 0)
		begin
			for (i = 0; i < dly; i++)
				tick(~io_in);
			for (i = 0; i < 8; i++)
			begin
				tick(~io_in);
				rd = {rd[6:0], smp[1]};
			end
		end
		for (i = 0; i < nx; i++)
			tick(~io_in);
		#8;
		link_cs_n = 1'b1;
		io_in = ~io_in;
	endtask : frame
endmodule : eccc_host_model

// ==== test/tb.sv ====
// ==========
// bench: queries, log clear, checksum runs, abort, suspend
module tb;
	timeunit 1ns;
	timeprecision 100ps;

	logic core_clk, reset, link_sclk, link_cs_n; // clocks and frame
	logic [3:0] io_in, io_out, io_oe; // serial lanes
	logic [1:0] lane_mode; // lane width
	logic [3:0] memory_latency_code; // dummy count
	logic [20:0] unit_query_addr, bad_unit; // queried and faulty unit
	logic unit_triple_error, arr_req, arr_ack, hit; // array port
	logic [23:0] arr_addr, sa; // byte address, range start
	logic [31:0] arr_rdata, checksum_result; // data and result
	logic write_enable_latch, wel_clear, error_log_clear_cmd;
	logic write_in_progress, checksum_abort_flag, checksum_suspended_flag;
	logic [7:0] mem [0:255]; // array contents, folded by address
	logic [7:0] rd; // answer byte
	int seed = 37, mismatches = 0, comparisons = 0, cycles = 0;
	int gap = 0, slow = 0, wel_cnt = 0, clr_cnt = 0, i, c0;

	eccc_engine i_eccc_engine (
		.core_clk(core_clk),
		.reset(reset),
		.link_sclk(link_sclk),
		.link_cs_n(link_cs_n),
		.io_in(io_in),
		.io_out(io_out),
		.io_oe(io_oe),
		.lane_mode(lane_mode),
		.memory_latency_code(memory_latency_code),
		.unit_query_addr(unit_query_addr),
		.unit_triple_error(unit_triple_error),
		.arr_req(arr_req),
		.arr_addr(arr_addr),
		.arr_ack(arr_ack),
		.arr_rdata(arr_rdata),
		.write_enable_latch(write_enable_latch),
		.wel_clear(wel_clear),
		.error_log_clear_cmd(error_log_clear_cmd),
		.write_in_progress(write_in_progress),
		.checksum_abort_flag(checksum_abort_flag),
		.checksum_suspended_flag(checksum_suspended_flag),
		.checksum_result(checksum_result)
	);

	eccc_host_model u_host (
		.link_sclk(link_sclk),
		.link_cs_n(link_cs_n),
		.io_in(io_in),
		.io_out(io_out),
		.lane_mode(lane_mode)
	);

	// ecc store: one faulty unit
	assign unit_triple_error = (unit_query_addr == bad_unit);

	initial
	begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	// array: variable wait per word, garbage between words
	always @(posedge core_clk)
	begin
		hit = !reset && arr_req && !arr_ack && gap == 0;
		arr_ack <= hit;
		arr_rdata <= hit ? {mem[arr_addr[7:0] + 8'd3],
			mem[arr_addr[7:0] + 8'd2], mem[arr_addr[7:0] + 8'd1],
			mem[arr_addr[7:0]]} : $random(seed);
		if (hit)
			gap <= slow ? 7 : $random(seed) & 3;
		else if (arr_req && !arr_ack && gap > 0)
			gap <= gap - 1;
	end

	// latch cleared by the pulse; pulses counted; hang limit
	always @(posedge core_clk)
	begin
		cycles++;
		if (wel_clear === 1'b1)
		begin
			write_enable_latch <= 1'b0;
			wel_cnt++;
		end
		if (error_log_clear_cmd === 1'b1)
			clr_cnt++;
		if (cycles == 20000)
		begin
			mismatches++;
			results();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic results();
		$display("compares %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : results

	// reference checksum: msb first, zero seed, byte stream order
	function automatic logic [31:0] crc_model(input int a0, input int a1);
		logic [31:0] c;
		int a, b;
		c = 32'h0;
		for (a = a0; a <= a1; a++)
		begin
			c = c ^ {mem[a & 255], 24'h0};
			for (b = 0; b < 8; b++)
				c = c[31] ? (c << 1) ^ 32'h1edc6f41 : c << 1;
		end
		return c;
	endfunction : crc_model

	task automatic cmd(input logic [7:0] op, input logic [23:0] a1,
		input logic [23:0] a2, input int na, input int nx);
		@(posedge core_clk);
		u_host.frame(op, a1, a2, na, 0, nx, rd);
		repeat (20) @(posedge core_clk);
		#1;
	endtask : cmd

	// unit query in single lane mode, latency ten
	task automatic query(input logic [23:0] a, input int nx);
		@(posedge core_clk);
		lane_mode <= 2'h0;
		memory_latency_code <= 4'ha;
		@(posedge core_clk);
		u_host.frame(8'h19, a, 24'h0, 1, 10, nx, rd);
		check(rd, {4'h0, a[23:3] == bad_unit, 3'h0});
		check(unit_query_addr, a[23:3]);
		repeat (8) @(posedge core_clk);
		check(io_oe, 4'h0);
		$display("query %h done", a);
	endtask : query

	// checksum run, optionally paused and resumed midway
	task automatic run_ck(input logic [23:0] s, input logic [23:0] e,
		input logic [1:0] m, input int sus);
		int n, w0;
		@(posedge core_clk);
		lane_mode <= m;
		write_enable_latch <= m[0];
		slow = sus;
		w0 = wel_cnt;
		@(posedge core_clk);
		u_host.frame(8'h5b, s, e, 2, 0, 0, rd);
		n = 0;
		while (write_in_progress !== 1'b1 && n < 40)
		begin
			@(posedge core_clk);
			#1;
			n++;
		end
		check(checksum_result, 32'h0);
		check(write_in_progress, 1'b1);
		if (sus)
		begin
			cmd(8'hb0, 24'h0, 24'h0, 0, 0);
			check(checksum_suspended_flag, 1'b0);
			cmd(8'h75, 24'h0, 24'h0, 0, 0);
			check({checksum_suspended_flag, write_in_progress}, 2'h2);
			query({bad_unit, 3'h0}, 0);
			cmd(8'h7a, 24'h0, 24'h0, 0, 0);
			check({checksum_suspended_flag, write_in_progress}, 2'h1);
		end
		while (write_in_progress !== 1'b0 && n < 4000)
		begin
			@(posedge core_clk);
			#1;
			n++;
		end
		check(checksum_result, crc_model(s, e));
		check(checksum_abort_flag, 1'b0);
		repeat (8) @(posedge core_clk);
		check(wel_cnt - w0, m[0]);
		$display("checksum %h to %h mode %0d done", s, e, m);
	endtask : run_ck

	initial
	begin
		reset = 1'b1;
		lane_mode = 2'h0;
		memory_latency_code = 4'ha;
		arr_ack = 1'b0;
		arr_rdata = 32'h0;
		write_enable_latch = 1'b0;
		for (i = 0; i < 256; i++)
			mem[i] = $random(seed);
		bad_unit = $random(seed) & 21'h01fff0;
		repeat (5) @(posedge core_clk);
		reset <= 1'b0;
		repeat (5) @(posedge core_clk);
		check(checksum_result, 32'h0);
		check(write_in_progress, 1'b0);
		query({bad_unit, 3'h5}, 0);
		query({bad_unit + 21'h1, 3'h0}, 8);
		c0 = clr_cnt;
		cmd(8'h1b, 24'h0, 24'h0, 0, 0);
		check(clr_cnt - c0, 1);
		$display("log clear done");
		for (i = 0; i < 3; i++)
		begin
			sa = $random(seed) & 24'h0ffe00;
			run_ck(sa, sa + 24'h3 + ($random(seed) & 31), i, 0);
		end
		run_ck(sa + 24'h1, sa + 24'h4, 2'h1, 0);
		cmd(8'h5b, sa, sa + 24'h2, 2, 0);
		check({checksum_abort_flag, write_in_progress}, 2'h2);
		cmd(8'h5b, sa, sa + 24'h8, 2, 1);
		check(write_in_progress, 1'b0);
		cmd(8'h7a, 24'h0, 24'h0, 0, 0);
		check({checksum_suspended_flag, write_in_progress}, 2'h0);
		$display("refusals done");
		run_ck(sa, sa + 24'hff, 2'h0, 1);
		results();
	end
endmodule : tb
